// ==== rtl/tswd_top.sv ====
// two-stage watchdog timer core
// What this block does
// - eight selectable timeouts, 0.25 s up to 256 s
// - two-stage mode raises an NMI before any system reset
// - missed strobe gives NMI, reset or both as configured; two-stage mode always gives the NMI
// - status bit set when watchdog caused a reset
// - cause bit cleared at power-up only
// - cause bit kept across ordinary resets, watchdog reset too
// - first and second stage expiries reported as separate events
`timescale 1ns/1ps
`include "tswd_map.svh"
module tswd_top #(
	// cycles per tick; overridable so short runs can reach an expiry
	parameter int unsigned TICK_CYC = `TSWD_TICK_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic                  por,
	input  wire logic                  strobe_pin,
	input  wire tswd_pkg::tswd_cfg_type cfg,
	output tswd_pkg::tswd_out_type     outs,
	output logic                       wd_caused_reset
);
	// strobe arrives from a pin: two-flop sync then edge detect
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic strobe;
	logic tick;
	tswd_pkg::tswd_state_type st_q;
	tswd_pkg::tswd_state_type st_d;
	logic [`TSWD_CNT_W-1:0]  cnt_q;
	logic [`TSWD_CNT_W-1:0]  cnt_d;
	logic [`TSWD_CNT_W-1:0]  load;
	tswd_pkg::tswd_out_type  o_q;
	tswd_pkg::tswd_out_type  o_d;
	logic                    cause_q;
	logic                    cause_d;
	logic                    expire;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= strobe_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign strobe = s2_q & ~s3_q;

	// period table in quarter-second ticks, 0.25 s up to 256 s
	always_comb begin
		case (cfg.period_sel)
		3'h0: load = `TSWD_PER0_TICKS;
		3'h1: load = `TSWD_PER1_TICKS;
		3'h2: load = `TSWD_PER2_TICKS;
		3'h3: load = `TSWD_PER3_TICKS;
		3'h4: load = `TSWD_PER4_TICKS;
		3'h5: load = `TSWD_PER5_TICKS;
		3'h6: load = `TSWD_PER6_TICKS;
		default: load = `TSWD_PER7_TICKS;
		endcase
	end
	assign expire = tick && (cnt_q == `TSWD_CNT_W'(1));

	tswd_tick #(.TICK_CYC(TICK_CYC)) u_tick (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.restart (strobe | ~cfg.enable),
		.tick    (tick)
	);

	// countdown and stage sequencing
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		o_d   = '0;
		if (!cfg.enable) begin
			st_d  = tswd_pkg::TSWD_OFF;
			cnt_d = load;
		end else if (strobe) begin
			// a strobe cancels any stage not yet reached
			st_d  = tswd_pkg::TSWD_STG1;
			cnt_d = load;
		end else begin
			if (tick && cnt_q != '0) begin
				cnt_d = cnt_q - `TSWD_CNT_W'(1);
			end
			case (st_q)
			tswd_pkg::TSWD_OFF: begin
				st_d  = tswd_pkg::TSWD_STG1;
				cnt_d = load;
			end
			tswd_pkg::TSWD_STG1: begin
				if (expire) begin
					o_d.stage1_event = 1'b1;
					if (cfg.two_stage) begin
						// nmi first, reset waits a second period
						o_d.nmi = 1'b1;
						st_d    = tswd_pkg::TSWD_STG2;
						cnt_d   = load;
					end else begin
						o_d.nmi       = cfg.nmi_en;
						o_d.sys_reset = cfg.rst_en;
						st_d          = tswd_pkg::TSWD_DONE;
					end
				end
			end
			tswd_pkg::TSWD_STG2: begin
				if (expire) begin
					o_d.stage2_event = 1'b1;
					o_d.sys_reset    = cfg.rst_en;
					st_d             = tswd_pkg::TSWD_DONE;
				end
			end
			tswd_pkg::TSWD_DONE: begin
				st_d = tswd_pkg::TSWD_DONE;
			end
			default: begin
				st_d = tswd_pkg::TSWD_OFF;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q  <= tswd_pkg::TSWD_OFF;
			cnt_q <= '0;
			o_q   <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			o_q   <= o_d;
		end
	end

	// cause bit: only power-up clears it, sys_rst does not
	always_comb begin
		cause_d = cause_q;
		if (o_q.sys_reset) begin
			cause_d = 1'b1;
		end else if (por) begin
			cause_d = `TSWD_CAUSE_RST;
		end
	end

	always_ff @(posedge mclk) begin
		cause_q <= cause_d;
	end

	assign outs            = o_q;
	assign wd_caused_reset = cause_q;

	property p_reset_sets_cause;
		@(posedge mclk) disable iff (por)
		o_q.sys_reset |=> cause_q;
	endproperty
	a_reset_sets_cause: assert property (p_reset_sets_cause)
		else $error("cause bit not set after watchdog reset");

	property p_por_clears;
		@(posedge mclk) (por && !o_q.sys_reset) |=> !cause_q;
	endproperty
	a_por_clears: assert property (p_por_clears)
		else $error("cause bit not cleared by power-up");

	property p_cause_kept;
		@(posedge mclk) (cause_q && !por) |=> cause_q;
	endproperty
	a_cause_kept: assert property (p_cause_kept)
		else $error("cause bit lost without power-up");

	property p_two_stage_nmi_first;
		@(posedge mclk) disable iff (sys_rst)
		(o_q.stage1_event && cfg.two_stage) |-> !o_q.sys_reset && o_q.nmi;
	endproperty
	a_two_stage_nmi_first: assert property (p_two_stage_nmi_first)
		else $error("two-stage expiry did not give nmi alone");

	property p_stage2_after_stage1;
		@(posedge mclk) disable iff (sys_rst)
		o_q.stage2_event |-> $past(st_q) == tswd_pkg::TSWD_STG2;
	endproperty
	a_stage2_after_stage1: assert property (p_stage2_after_stage1)
		else $error("second stage without first");

	property p_stages_separate;
		@(posedge mclk) disable iff (sys_rst)
		!(o_q.stage1_event && o_q.stage2_event);
	endproperty
	a_stages_separate: assert property (p_stages_separate)
		else $error("both stage events in one cycle");

	property p_two_stage_reset_late;
		@(posedge mclk) disable iff (sys_rst)
		(o_q.sys_reset && $past(cfg.two_stage)) |-> o_q.stage2_event;
	endproperty
	a_two_stage_reset_late: assert property (p_two_stage_reset_late)
		else $error("two-stage reset without second stage");

	property p_strobe_reload;
		@(posedge mclk) disable iff (sys_rst)
		(strobe && cfg.enable) |=> cnt_q == $past(load)
			&& st_q == tswd_pkg::TSWD_STG1;
	endproperty
	a_strobe_reload: assert property (p_strobe_reload)
		else $error("strobe did not restart full period");

	property p_period_range;
		@(posedge mclk) disable iff (sys_rst)
		cnt_q <= `TSWD_CNT_W'(1024);
	endproperty
	a_period_range: assert property (p_period_range)
		else $error("countdown beyond 256 s");

	property p_single_stage;
		@(posedge mclk) disable iff (sys_rst)
		(o_q.stage1_event && !cfg.two_stage && $stable(cfg))
			|-> o_q.sys_reset == cfg.rst_en && o_q.nmi == cfg.nmi_en;
	endproperty
	a_single_stage: assert property (p_single_stage)
		else $error("single-stage action not as configured");
endmodule // tswd_top

// ==== inc/tswd_map.svh ====
// constants of the two-stage watchdog: timing and reset values
`ifndef TSWD_MAP_SVH
`define TSWD_MAP_SVH
`define TSWD_CLK_HZ        40000000
`define TSWD_TICK_MS       250
`define TSWD_TICK_CYC      ((`TSWD_CLK_HZ / 1000) * `TSWD_TICK_MS)
`define TSWD_PERIOD_W      3
`define TSWD_TICK_W        24
`define TSWD_CNT_W         11
// quarter-second ticks per period; the ends are fixed, middle steps chosen
`define TSWD_PER0_TICKS    11'h001
`define TSWD_PER1_TICKS    11'h002
`define TSWD_PER2_TICKS    11'h004
`define TSWD_PER3_TICKS    11'h008
`define TSWD_PER4_TICKS    11'h010
`define TSWD_PER5_TICKS    11'h040
`define TSWD_PER6_TICKS    11'h100
`define TSWD_PER7_TICKS    11'h400
`define TSWD_PERIOD_RST    3'h0
`define TSWD_CAUSE_RST     1'h0
`endif

// ==== inc/tswd_pkg.sv ====
// types of the two-stage watchdog
package tswd_pkg;
	typedef enum logic [3:0] {
		TSWD_OFF   = 4'h1,
		TSWD_STG1  = 4'h2,
		TSWD_STG2  = 4'h4,
		TSWD_DONE  = 4'h8
	} tswd_state_type;

	typedef struct packed {
		logic       enable;
		logic       nmi_en;
		logic       rst_en;
		logic       two_stage;
		logic [2:0] period_sel;
	} tswd_cfg_type;

	typedef struct packed {
		logic nmi;
		logic sys_reset;
		logic stage1_event;
		logic stage2_event;
	} tswd_out_type;
endpackage

// ==== rtl/tswd_tick.sv ====
// quarter-second tick divider for the watchdog
`timescale 1ns/1ps
`include "tswd_map.svh"
module tswd_tick #(
	parameter int unsigned TICK_CYC = `TSWD_TICK_CYC
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic restart,
	output logic      tick
);
	localparam logic [`TSWD_TICK_W-1:0] TOP =
		`TSWD_TICK_W'(TICK_CYC - 1);
	logic [`TSWD_TICK_W-1:0] cnt_q;
	logic [`TSWD_TICK_W-1:0] cnt_d;
	logic                    tick_q;
	logic                    tick_d;

	// restart realigns so a strobe always grants a full period
	always_comb begin
		cnt_d  = cnt_q + `TSWD_TICK_W'(1);
		tick_d = 1'b0;
		if (restart) begin
			cnt_d = '0;
		end else if (cnt_q == TOP) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick = tick_q;
endmodule // tswd_tick

// ==== test/tswd_host.sv ====
// host model: drives the strobe pin on request
`timescale 1ns/1ps
module tswd_host (
	input  wire logic mclk,
	input  wire logic kick,
	output logic      strobe_pin
);
	logic [2:0] hold_q;

	// pin held several cycles so the two sync flops see it
	always @(posedge mclk) begin
		if (kick)
			hold_q <= 3'h4;
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
	end

	initial hold_q = 3'h0;
	assign strobe_pin = (hold_q != 3'h0);
endmodule // tswd_host

// ==== test/tswd_top_tb.sv ====
// self-checking bench for the two-stage watchdog
`timescale 1ns/1ps
module tswd_top_tb;
	logic                   mclk;
	logic                   sys_rst;
	logic                   por;
	logic                   kick;
	logic                   strobe_pin;
	tswd_pkg::tswd_cfg_type cfg;
	tswd_pkg::tswd_out_type outs;
	logic                   wd_caused_reset;
	logic [3:0]             seen;
	int                     failures;
	int                     n_compared;
	// short tick so every period fits the run
	localparam int          TB_TICK = 8;
	localparam logic [3:0]  EV_NMI  = 4'h8;
	localparam logic [3:0]  EV_RST  = 4'h4;
	localparam logic [3:0]  EV_S1   = 4'h2;
	localparam logic [3:0]  EV_S2   = 4'h1;

	tswd_top #(.TICK_CYC(TB_TICK)) tswd_top_inst (.mclk(mclk),
		.sys_rst(sys_rst), .por(por),
		.strobe_pin(strobe_pin), .cfg(cfg), .outs(outs),
		.wd_caused_reset(wd_caused_reset));
	tswd_host tswd_host_inst (.mclk(mclk), .kick(kick),
		.strobe_pin(strobe_pin));

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// pulses last one cycle, so keep any seen until cleared
	always @(negedge mclk) seen <= seen | outs;

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask

	task automatic check(input string what, input logic [3:0] exp,
		input logic [3:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp,
		input logic got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one host strobe: kick raised for one edge
	task automatic kick_once();
		kick = 1'b1;
		cyc(1);
		kick = 1'b0;
	endtask

	// gap under 4 would merge strobes inside the host's hold time
	task automatic strobe_every(input int gap, input int n);
		repeat (n) begin
			kick_once();
			cyc(gap);
		end
	endtask

	// disable for one edge so state and tick restart, then arm
	task automatic arm(input tswd_pkg::tswd_cfg_type c);
		cfg = 7'h00;
		cyc(1);
		seen = 4'h0;
		cfg = c;
	endtask

	task automatic print_verdict();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// power-up clears the cause bit that the reset left standing
	task automatic t_power();
		cfg = 7'h00;
		por = 1'b1;
		cyc(2);
		por = 1'b0;
		cyc(2);
		check_bit("cause clear", 1'b0, wd_caused_reset);
		$display("t_power done");
	endtask

	// ordinary reset mid-run leaves cause bit alone, outputs quiet
	task automatic t_reset_keep();
		sys_rst = 1'b1;
		cyc(3);
		sys_rst = 1'b0;
		cyc(2);
		check_bit("cause kept", 1'b1, wd_caused_reset);
		check("outs quiet", 4'h0, outs);
		$display("t_reset_keep done");
	endtask

	// timer off: strobes and waiting wake nothing
	task automatic t_disabled();
		cfg = 7'h38;
		seen = 4'h0;
		strobe_every(5, 5);
		cyc(40);
		check("seen off", 4'h0, seen);
		check_bit("cause boot", 1'b0, wd_caused_reset);
		$display("t_disabled done");
	endtask

	// strobes faster than the period hold off every expiry
	task automatic t_strobed();
		arm(7'h78);
		strobe_every(5, 20);
		check("seen sel0", 4'h0, seen);
		arm(7'h7F);
		strobe_every(300, 5);
		check("seen sel7", 4'h0, seen);
		$display("t_strobed done");
	endtask

	// single stage, one tick: actions as configured, then quiet
	task automatic t_single();
		arm(7'h60);
		cyc(8);
		check("outs early", 4'h0, outs);
		cyc(1);
		check("outs nmi", EV_NMI | EV_S1, outs);
		cyc(1);
		check("outs one", 4'h0, outs);
		check_bit("cause nmi", 1'b0, wd_caused_reset);
		arm(7'h50);
		cyc(9);
		check("outs rst", EV_RST | EV_S1, outs);
		cyc(1);
		check_bit("cause rst", 1'b1, wd_caused_reset);
		arm(7'h70);
		cyc(9);
		check("outs both", EV_NMI | EV_RST | EV_S1, outs);
		cyc(30);
		check("seen done", EV_NMI | EV_RST | EV_S1, seen);
		$display("t_single done");
	endtask

	// two stage: nmi alone first, reset one full period later
	task automatic t_two_stage();
		arm(7'h78);
		cyc(9);
		check("outs stage1", EV_NMI | EV_S1, outs);
		cyc(8);
		check("seen before", EV_NMI | EV_S1, seen);
		check("outs stage2", EV_RST | EV_S2, outs);
		cyc(1);
		check_bit("cause two", 1'b1, wd_caused_reset);
		// a strobe after the nmi cancels the pending reset
		arm(7'h78);
		cyc(9);
		kick_once();
		cyc(10);
		check("seen cancel", EV_NMI | EV_S1, seen);
		cyc(2);
		check("outs restart", EV_NMI | EV_S1, outs);
		$display("t_two_stage done");
	endtask

	// longest period: expiry exactly 1024 ticks after arming
	task automatic t_long();
		arm(7'h57);
		cyc(TB_TICK * 1024);
		check("outs sel7 early", 4'h0, outs);
		cyc(1);
		check("outs sel7", EV_RST | EV_S1, outs);
		$display("t_long done");
	endtask

	// cut a hang short; the whole run needs about 10000 cycles
	initial begin
		#(25 * 20000);
		failures++;
		print_verdict();
	end

	initial begin
		sys_rst = 1'b1;
		por = 1'b1;
		kick = 1'b0;
		cfg = 7'h00;
		seen = 4'h0;
		failures = 0;
		n_compared = 0;
		cyc(2);
		sys_rst = 1'b0;
		por = 1'b0;
		t_disabled();
		t_strobed();
		t_single();
		t_reset_keep();
		t_power();
		t_two_stage();
		t_long();
		print_verdict();
	end
endmodule // tswd_top_tb
